// ==== src/pfs_consts.svh ====
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH

// register byte offsets on the bus, one aligned word each
`define PFS_OFF_PORT_A_SELECT_LOW  8'h00
`define PFS_OFF_PORT_A_SELECT_HIGH 8'h04
`define PFS_OFF_PORT_B_SELECT_LOW  8'h08
`define PFS_OFF_PORT_B_SELECT_HIGH 8'h0c
`define PFS_OFF_PORT_C_SELECT_LOW  8'h10
`define PFS_OFF_PORT_C_SELECT_HIGH 8'h14
`define PFS_ADDR_W                 8
`define PFS_NUM_SEL                6

// every selection register clears at reset
`define PFS_SEL_RESET              8'h00

// field codes, two bits per pin
`define PFS_CODE_GPIO              2'b00
`define PFS_CODE_ALT               2'b01
`define PFS_CODE_PERIPH            2'b10
`define PFS_CODE_ANALOG            2'b11

// field of pin bit b sits at bits 2*(b mod 4)+1 : 2*(b mod 4)
`define PFS_FIELD_W                2
`define PFS_PINS_PER_REG           4

// port indices inside the pad vectors
`define PFS_PORT_A                 0
`define PFS_PORT_B                 1
`define PFS_PORT_C                 2
`define PFS_NUM_PORTS              3

// analog channel and comparator input count
`define PFS_NUM_AN                 19
`define PFS_NUM_CMP_IN             4

// axi responses
`define PFS_RESP_OKAY              2'b00
`define PFS_RESP_SLVERR            2'b10

`endif

// ==== src/pfs_pkg.sv ====
package pfs_pkg;

  typedef logic [1:0] pfs_code_t;

  // peripheral side drive towards the pads
  typedef struct packed {
    logic spi_a_serial_clock;
    logic spi_a_serial_clock_oe;
    logic spi_a_data_out;
    logic spi_a_data_out_oe;
    logic spi_a_chip_select;
    logic spi_a_chip_select_oe;
    logic comparator0_output;
    logic comparator1_output;
    logic periodic_timer0_output;
    logic periodic_timer4_output;
    logic standard_timer_output;
    logic serial_chip_select;
    logic serial_chip_select_oe;
    logic serial_clock;
    logic serial_clock_oe;
    logic serial_data_in_scl;
    logic serial_data_in_scl_oe;
    logic serial_data_out_sda;
    logic serial_data_out_sda_oe;
    logic uart_transmit;
  } pfs_periph_out_t;

  // pad levels handed to the peripherals
  typedef struct packed {
    logic spi_a_serial_clock;
    logic spi_a_data_in;
    logic spi_a_chip_select;
    logic periodic_timer0_clock_in;
    logic periodic_timer0_capture_in;
    logic periodic_timer4_clock_in;
    logic periodic_timer4_capture_in;
    logic standard_timer_clock_in;
    logic standard_timer_capture_in;
    logic external_interrupt0;
    logic external_interrupt1;
    logic serial_chip_select;
    logic serial_clock;
    logic serial_data_in_scl;
    logic serial_data_out_sda;
    logic uart_receive;
  } pfs_periph_in_t;

endpackage : pfs_pkg

// ==== src/pfs_pin_cell.sv ====
`timescale 1ns/100ps
`include "pfs_consts.svh"

// one pad: peripheral or gpio drive, analog disconnects the digital path
module pfs_pin_cell
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin_sync,
  input  wire logic gpio_out,
  input  wire logic gpio_oe,
  input  wire logic periph_drive,
  input  wire logic periph_out,
  input  wire logic periph_oe,
  input  wire logic analog,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      gpio_in
);
  import pfs_pkg::*;

  wire next_out = periph_drive ? periph_out : gpio_out;
  wire next_oe  = analog ? 1'b0 : (periph_drive ? periph_oe : gpio_oe);
  // analog pins read as zero so a floating level cannot toggle logic
  wire next_in  = analog ? 1'b0 : pin_sync;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pad_out <= 1'b0;
      pad_oe  <= 1'b0;
      gpio_in <= 1'b0;
    end
    else
    begin
      pad_out <= next_out;
      pad_oe  <= next_oe;
      gpio_in <= next_in;
    end
  end

endmodule : pfs_pin_cell

// ==== src/pfs_pin_function_select.sv ====
// Summary of operation
// - port A bit 3: gpio, spi A clock on 10, comparator 0 minus on 11
// - port A bit 2: gpio, spi A data in on 10, comparator 0 plus on 11
// - port A bit 1: gpio, spi A data out on 10, comparator 0 out on 11
// - port A bit 0 is always gpio plus periodic timer 0 clock
// - port A bit 7: gpio with interrupt 0, analog channel 7 on 11
// - port A bit 6: gpio with timer clock, comparator 1 minus on 11
// - port A bit 5: gpio/capture, timer 0 out on 10, comparator 1 plus
// - port A bit 4: capture, spi A select, timer out, comparator 1 out
// - port B bit 3: gpio, serial chip select on 10, analog 3 on 11
// - port B bit 2: gpio, serial clock on 10, analog 2 on 11
// - port B bit 1: gpio, serial data in or scl on 10, analog 1
// - port B bit 0: gpio, serial data out or sda on 10, analog 0
// - port B bit 7: gpio/capture 4, timer 4 out on 10, analog 18
// - port B bit 6: gpio with interrupt 1, analog channel 6 on 11
// - port B bit 5: gpio, analog channel 5 on 11
// - port B bit 4: gpio/capture, timer out on 10, analog 4 on 11
// - port C bits 3 and 2: gpio, analog 11 and 10 on 11
// - port C bit 1: gpio with timer 4 clock, analog 9 on 11
// - port C bit 0: gpio/capture 4, timer 4 out on 10, analog 8
// - port C bits 7 and 6: gpio, analog 15 and 14 on 11
// - port C bits 5 and 4: gpio, uart rx/tx on 10, analog 13/12
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "pfs_consts.svh"

module pfs_pin_function_select
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  input  wire logic [2:0][7:0]       pin_in,
  output logic      [2:0][7:0]       pad_out,
  output logic      [2:0][7:0]       pad_oe,
  input  wire logic [2:0][7:0]       gpio_out,
  input  wire logic [2:0][7:0]       gpio_oe,
  output logic      [2:0][7:0]       gpio_in,
  input  wire pfs_pkg::pfs_periph_out_t periph_out,
  output pfs_pkg::pfs_periph_in_t    periph_in,
  output logic [18:0]                analog_channel_en,
  output logic [3:0]                 comparator_in_en
);
  import pfs_pkg::*;

  // selection registers, index = port*2 + high half
  logic [7:0] sel_reg [`PFS_NUM_SEL];

  // ---- axi4-lite write path: address and data taken in either order
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [7:0]  w_data;
  logic        w_strb0;

  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    unique case (addr)
      `PFS_OFF_PORT_A_SELECT_LOW:  reg_index = 4'h0;
      `PFS_OFF_PORT_A_SELECT_HIGH: reg_index = 4'h1;
      `PFS_OFF_PORT_B_SELECT_LOW:  reg_index = 4'h2;
      `PFS_OFF_PORT_B_SELECT_HIGH: reg_index = 4'h3;
      `PFS_OFF_PORT_C_SELECT_LOW:  reg_index = 4'h4;
      `PFS_OFF_PORT_C_SELECT_HIGH: reg_index = 4'h5;
      default:                     reg_index = 4'hf;
    endcase
  endfunction : reg_index

  wire       do_write  = aw_held && w_held && !s_axi_bvalid;
  wire [3:0] wr_index  = reg_index(aw_addr);
  wire       wr_mapped = (wr_index != 4'hf);

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held  <= 1'b0;
      w_data  <= 8'h00;
      w_strb0 <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held  <= 1'b1;
      w_data  <= s_axi_wdata[7:0];
      w_strb0 <= s_axi_wstrb[0];
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PFS_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? `PFS_RESP_OKAY : `PFS_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // only byte lane 0 holds register bits; other lanes are ignored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int r = 0; r < `PFS_NUM_SEL; r++)
        sel_reg[r] <= `PFS_SEL_RESET;
    end
    else if (do_write && wr_mapped && w_strb0)
      sel_reg[wr_index[2:0]] <= w_data;
  end

  // ---- axi4-lite read path
  wire [3:0] rd_index = reg_index(s_axi_araddr);
  wire       rd_ok    = (rd_index != 4'hf);
  wire [7:0] rd_byte  = rd_ok ? sel_reg[rd_index[2:0]] : 8'h00;

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PFS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_ok ? `PFS_RESP_OKAY : `PFS_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ---- per-pin field codes
  pfs_code_t code [`PFS_NUM_PORTS][8];

  for (genvar p = 0; p < `PFS_NUM_PORTS; p++)
  begin : g_port
    for (genvar b = 0; b < 8; b++)
    begin : g_bit
      assign code[p][b] =
        sel_reg[p * 2 + b / `PFS_PINS_PER_REG]
               [(b % `PFS_PINS_PER_REG) * `PFS_FIELD_W +: `PFS_FIELD_W];
    end
  end

  // ---- pin synchroniser: pads are asynchronous to aclk
  logic [2:0][7:0] pin_meta;
  logic [2:0][7:0] pin_sync;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // ---- output function table
  logic [2:0][7:0] drive;
  logic [2:0][7:0] per_o;
  logic [2:0][7:0] per_oe;
  logic [2:0][7:0] analog;
  logic [18:0]     next_an;
  logic [3:0]      next_cmp;

  wire pfs_periph_out_t po = periph_out;

  always_comb
  begin
    drive    = '0;
    per_o    = '0;
    per_oe   = '0;
    analog   = '0;
    next_an  = '0;
    next_cmp = '0;
    if (code[`PFS_PORT_A][3] == `PFS_CODE_PERIPH)
    begin
      drive[`PFS_PORT_A][3]  = 1'b1;
      per_o[`PFS_PORT_A][3]  = po.spi_a_serial_clock;
      per_oe[`PFS_PORT_A][3] = po.spi_a_serial_clock_oe;
    end
    if (code[`PFS_PORT_A][3] == `PFS_CODE_ANALOG)
    begin
      analog[`PFS_PORT_A][3] = 1'b1;
      next_cmp[0]            = 1'b1;
    end
    if (code[`PFS_PORT_A][2] == `PFS_CODE_ANALOG)
    begin
      analog[`PFS_PORT_A][2] = 1'b1;
      next_cmp[1]            = 1'b1;
    end
    if (code[`PFS_PORT_A][1] == `PFS_CODE_PERIPH)
    begin
      drive[`PFS_PORT_A][1]  = 1'b1;
      per_o[`PFS_PORT_A][1]  = po.spi_a_data_out;
      per_oe[`PFS_PORT_A][1] = po.spi_a_data_out_oe;
    end
    if (code[`PFS_PORT_A][1] == `PFS_CODE_ANALOG)
    begin
      drive[`PFS_PORT_A][1]  = 1'b1;
      per_o[`PFS_PORT_A][1]  = po.comparator0_output;
      per_oe[`PFS_PORT_A][1] = 1'b1;
    end
    if (code[`PFS_PORT_A][7] == `PFS_CODE_ANALOG)
    begin
      analog[`PFS_PORT_A][7] = 1'b1;
      next_an[7]             = 1'b1;
    end
    if (code[`PFS_PORT_A][6] == `PFS_CODE_ANALOG)
    begin
      analog[`PFS_PORT_A][6] = 1'b1;
      next_cmp[2]            = 1'b1;
    end
    if (code[`PFS_PORT_A][5] == `PFS_CODE_PERIPH)
    begin
      drive[`PFS_PORT_A][5]  = 1'b1;
      per_o[`PFS_PORT_A][5]  = po.periodic_timer0_output;
      per_oe[`PFS_PORT_A][5] = 1'b1;
    end
    if (code[`PFS_PORT_A][5] == `PFS_CODE_ANALOG)
    begin
      analog[`PFS_PORT_A][5] = 1'b1;
      next_cmp[3]            = 1'b1;
    end
    drive[`PFS_PORT_A][4] = (code[`PFS_PORT_A][4] != `PFS_CODE_GPIO);
    unique case (code[`PFS_PORT_A][4])
      `PFS_CODE_GPIO:
      begin
        per_o[`PFS_PORT_A][4]  = 1'b0;
        per_oe[`PFS_PORT_A][4] = 1'b0;
      end
      `PFS_CODE_ALT:
      begin
        per_o[`PFS_PORT_A][4]  = po.spi_a_chip_select;
        per_oe[`PFS_PORT_A][4] = po.spi_a_chip_select_oe;
      end
      `PFS_CODE_PERIPH:
      begin
        per_o[`PFS_PORT_A][4]  = po.standard_timer_output;
        per_oe[`PFS_PORT_A][4] = 1'b1;
      end
      `PFS_CODE_ANALOG:
      begin
        per_o[`PFS_PORT_A][4]  = po.comparator1_output;
        per_oe[`PFS_PORT_A][4] = 1'b1;
      end
    endcase
    // port B and C: code 11 is an analog channel on every bit here
    for (int b = 0; b < 8; b++)
    begin
      analog[`PFS_PORT_B][b] = (code[`PFS_PORT_B][b] == `PFS_CODE_ANALOG);
      analog[`PFS_PORT_C][b] = (code[`PFS_PORT_C][b] == `PFS_CODE_ANALOG);
    end
    next_an[6:0]   = {analog[`PFS_PORT_B][6:0]};
    next_an[15:8]  = analog[`PFS_PORT_C];
    next_an[18]    = analog[`PFS_PORT_B][7];
    next_an[7]     = analog[`PFS_PORT_A][7];
    if (code[`PFS_PORT_B][3] == `PFS_CODE_PERIPH)
    begin
      drive[`PFS_PORT_B][3]  = 1'b1;
      per_o[`PFS_PORT_B][3]  = po.serial_chip_select;
      per_oe[`PFS_PORT_B][3] = po.serial_chip_select_oe;
    end
    if (code[`PFS_PORT_B][2] == `PFS_CODE_PERIPH)
    begin
      drive[`PFS_PORT_B][2]  = 1'b1;
      per_o[`PFS_PORT_B][2]  = po.serial_clock;
      per_oe[`PFS_PORT_B][2] = po.serial_clock_oe;
    end
    if (code[`PFS_PORT_B][1] == `PFS_CODE_PERIPH)
    begin
      drive[`PFS_PORT_B][1]  = 1'b1;
      per_o[`PFS_PORT_B][1]  = po.serial_data_in_scl;
      per_oe[`PFS_PORT_B][1] = po.serial_data_in_scl_oe;
    end
    if (code[`PFS_PORT_B][0] == `PFS_CODE_PERIPH)
    begin
      drive[`PFS_PORT_B][0]  = 1'b1;
      per_o[`PFS_PORT_B][0]  = po.serial_data_out_sda;
      per_oe[`PFS_PORT_B][0] = po.serial_data_out_sda_oe;
    end
    if (code[`PFS_PORT_B][7] == `PFS_CODE_PERIPH)
    begin
      drive[`PFS_PORT_B][7]  = 1'b1;
      per_o[`PFS_PORT_B][7]  = po.periodic_timer4_output;
      per_oe[`PFS_PORT_B][7] = 1'b1;
    end
    if (code[`PFS_PORT_B][4] == `PFS_CODE_PERIPH)
    begin
      drive[`PFS_PORT_B][4]  = 1'b1;
      per_o[`PFS_PORT_B][4]  = po.standard_timer_output;
      per_oe[`PFS_PORT_B][4] = 1'b1;
    end
    if (code[`PFS_PORT_C][0] == `PFS_CODE_PERIPH)
    begin
      drive[`PFS_PORT_C][0]  = 1'b1;
      per_o[`PFS_PORT_C][0]  = po.periodic_timer4_output;
      per_oe[`PFS_PORT_C][0] = 1'b1;
    end
    if (code[`PFS_PORT_C][4] == `PFS_CODE_PERIPH)
    begin
      drive[`PFS_PORT_C][4]  = 1'b1;
      per_o[`PFS_PORT_C][4]  = po.uart_transmit;
      per_oe[`PFS_PORT_C][4] = 1'b1;
    end
  end

  // ---- pads: one cell per pin, registered towards the pad
  for (genvar p = 0; p < `PFS_NUM_PORTS; p++)
  begin : g_cell_port
    for (genvar b = 0; b < 8; b++)
    begin : g_cell
      pfs_pin_cell u_cell
      (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .pin_sync     (pin_sync[p][b]),
        .gpio_out     (gpio_out[p][b]),
        .gpio_oe      (gpio_oe[p][b]),
        .periph_drive (drive[p][b]),
        .periph_out   (per_o[p][b]),
        .periph_oe    (per_oe[p][b]),
        .analog       (analog[p][b]),
        .pad_out      (pad_out[p][b]),
        .pad_oe       (pad_oe[p][b]),
        .gpio_in      (gpio_in[p][b])
      );
    end
  end

  // ---- input function gating; idle level 1 for selects and uart rx
  function automatic logic gate(input logic en, input logic lvl,
                                input logic idle);
    gate = en ? lvl : idle;
  endfunction : gate

  function automatic logic shared(input pfs_code_t c);
    shared = (c == `PFS_CODE_GPIO) || (c == `PFS_CODE_ALT);
  endfunction : shared

  pfs_periph_in_t next_pi;
  wire [2:0][7:0] s = pin_sync;

  assign next_pi.spi_a_serial_clock =
    gate(code[0][3] == `PFS_CODE_PERIPH, s[0][3], 1'b0);
  assign next_pi.spi_a_data_in =
    gate(code[0][2] == `PFS_CODE_PERIPH, s[0][2], 1'b0);
  assign next_pi.spi_a_chip_select =
    gate(code[0][4] == `PFS_CODE_ALT, s[0][4], 1'b1);
  assign next_pi.periodic_timer0_clock_in = s[0][0];
  assign next_pi.periodic_timer0_capture_in =
    gate(shared(code[0][5]), s[0][5], 1'b0);
  assign next_pi.external_interrupt0 =
    gate(code[0][7] != `PFS_CODE_ANALOG, s[0][7], 1'b0);
  assign next_pi.standard_timer_clock_in =
    gate(code[0][6] != `PFS_CODE_ANALOG, s[0][6], 1'b0);
  // two capture sources: port A bit 4 takes precedence over port B bit 4
  assign next_pi.standard_timer_capture_in =
    (code[0][4] == `PFS_CODE_GPIO) ? s[0][4] :
    gate(shared(code[1][4]), s[1][4], 1'b0);
  assign next_pi.serial_chip_select =
    gate(code[1][3] == `PFS_CODE_PERIPH, s[1][3], 1'b1);
  assign next_pi.serial_clock =
    gate(code[1][2] == `PFS_CODE_PERIPH, s[1][2], 1'b0);
  assign next_pi.serial_data_in_scl =
    gate(code[1][1] == `PFS_CODE_PERIPH, s[1][1], 1'b0);
  assign next_pi.serial_data_out_sda =
    gate(code[1][0] == `PFS_CODE_PERIPH, s[1][0], 1'b0);
  assign next_pi.external_interrupt1 =
    gate(code[1][6] != `PFS_CODE_ANALOG, s[1][6], 1'b0);
  // likewise port B bit 7 wins over port C bit 0 for timer 4 capture
  assign next_pi.periodic_timer4_capture_in =
    shared(code[1][7]) ? s[1][7] :
    gate(shared(code[2][0]), s[2][0], 1'b0);
  assign next_pi.periodic_timer4_clock_in =
    gate(code[2][1] != `PFS_CODE_ANALOG, s[2][1], 1'b0);
  assign next_pi.uart_receive =
    gate(code[2][5] == `PFS_CODE_PERIPH, s[2][5], 1'b1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      periph_in         <= '0;
      analog_channel_en <= '0;
      comparator_in_en  <= '0;
    end
    else
    begin
      periph_in         <= next_pi;
      analog_channel_en <= next_an;
      comparator_in_en  <= next_cmp;
    end
  end

  // ---- checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_write_a_low;
    do_write && aw_addr == `PFS_OFF_PORT_A_SELECT_LOW && w_strb0;
  endsequence

  sequence s_resp_ok;
    s_axi_bvalid && s_axi_bresp == `PFS_RESP_OKAY;
  endsequence

  a_write_reg_update: assert property (
    s_write_a_low |=> s_resp_ok ##0 sel_reg[0] == $past(w_data))
    else $error("selection register write lost");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid[*1] ##0
      s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read answer missing");
  a_pa3_spi_clock: assert property (
    code[0][3] == `PFS_CODE_PERIPH |=>
      pad_out[0][3] == $past(po.spi_a_serial_clock))
    else $error("spi clock not on port a bit 3");
  a_pa2_spi_in: assert property (
    code[0][2] == `PFS_CODE_PERIPH |=>
      periph_in.spi_a_data_in == $past(pin_sync[0][2]))
    else $error("spi data in not routed");
  a_pa1_cmp_out: assert property (
    code[0][1] == `PFS_CODE_ANALOG |=>
      pad_oe[0][1] && pad_out[0][1] == $past(po.comparator0_output))
    else $error("comparator 0 output not driven");
  a_pa0_timer_clk: assert property (
    ##1 periph_in.periodic_timer0_clock_in == $past(pin_sync[0][0]))
    else $error("timer 0 clock not routed");
  a_pa7_analog: assert property (
    code[0][7] == `PFS_CODE_ANALOG |=>
      analog_channel_en[7] && !pad_oe[0][7])
    else $error("analog 7 not selected");
  a_pa4_chip_sel: assert property (
    code[0][4] == `PFS_CODE_ALT |=>
      pad_out[0][4] == $past(po.spi_a_chip_select))
    else $error("spi select not on port a bit 4");
  a_pb0_sda_drive: assert property (
    code[1][0] == `PFS_CODE_PERIPH |=>
      pad_oe[1][0] == $past(po.serial_data_out_sda_oe))
    else $error("sda enable not routed");
  a_pc4_uart_tx: assert property (
    code[2][4] == `PFS_CODE_PERIPH |=>
      pad_oe[2][4] && pad_out[2][4] == $past(po.uart_transmit))
    else $error("uart transmit not driven");
  a_gpio_default: assert property (
    code[0][3] == `PFS_CODE_GPIO |=>
      pad_out[0][3] == $past(gpio_out[0][3]) &&
      periph_in.spi_a_serial_clock == 1'b0)
    else $error("gpio path not kept");

endmodule : pfs_pin_function_select

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
`include "pfs_consts.svh"
module tb;
  import pfs_pkg::*;
  logic            aclk = 0, aresetn = 0, s_axi_awready, s_axi_wready;
  logic            s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic            s_axi_arvalid = 0, s_axi_rready = 0, s_axi_arready;
  logic            s_axi_bvalid, s_axi_rvalid;
  logic [7:0]      s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0]      s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0]     s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]      s_axi_wstrb = 4'hf;
  logic [1:0]      s_axi_bresp, s_axi_rresp;
  logic [2:0][7:0] pin_in = '0, gpio_out = '0, gpio_oe = '0;
  logic [2:0][7:0] pad_out, pad_oe, gpio_in;
  pfs_periph_out_t periph_out = '0;
  pfs_periph_in_t  periph_in;
  logic [18:0]     analog_channel_en;
  logic [3:0]      comparator_in_en;
  logic [33:0]     exp_q[$];
  logic [7:0]      offs[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [7:0]      d;
  int              n_fail = 0, samples_checked = 0, cyc = 0;
  pfs_pin_function_select dut_u (.*);
  always #2 aclk = ~aclk;
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // results are matched in order at the edge where the answer is taken
  always @(negedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready)
      chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] r);
    logic aw, w, b, ra, rw, rb;
    {aw, w, b} = 3'b111;
    exp_q.push_back({r, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'($urandom), v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (aw | w | b)
    begin
      @(negedge aclk);
      {ra, rw, rb} = {s_axi_awready & aw, s_axi_wready & w, s_axi_bvalid};
      // locals are automatic: step them here, the bus follows at the edge
      {aw, w, b} = {aw & !ra, w & !rw, b & !rb};
      @(posedge aclk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {aw, w, b};
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] r);
    logic ar, rb;
    ar = 1;
    rb = 1;
    exp_q.push_back({r, 24'h0, v});
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (rb)
    begin
      @(negedge aclk);
      ar = ar & !s_axi_arready;
      rb = !s_axi_rvalid;
      @(posedge aclk);
      {s_axi_arvalid, s_axi_rready} <= {ar, rb};
    end
  endtask : rd
  // new selection plus fresh random pad and peripheral levels, then settle
  task automatic sel(input logic [7:0] a, input logic [7:0] v);
    wr(a, v, `PFS_RESP_OKAY); // pin first, peripheral after
    periph_out <= 20'($urandom);
    gpio_out <= 24'($urandom);
    gpio_oe <= 24'($urandom);
    pin_in <= 24'($urandom);
    repeat (6) @(posedge aclk);
    @(negedge aclk);
  endtask : sel
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end
  initial
  begin
    void'($urandom(32'hcad8));
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    foreach (offs[i]) rd(offs[i], `PFS_SEL_RESET, `PFS_RESP_OKAY);
    foreach (offs[i])
    begin
      d = 8'($urandom);
      wr(offs[i], d, `PFS_RESP_OKAY);
      rd(offs[i], d, `PFS_RESP_OKAY);
    end
    // lane 0 strobe off: accepted, register keeps its value
    s_axi_wstrb <= 4'he;
    wr(8'h14, ~d, `PFS_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(8'h14, d, `PFS_RESP_OKAY);
    // unmapped place: refused, nothing stored
    wr(8'h18, 8'h5a, `PFS_RESP_SLVERR);
    rd(8'h18, 8'h00, `PFS_RESP_SLVERR);
    $display("test registers done");
    sel(8'h00, 8'ha0);
    chk(pad_out[0][3], periph_out.spi_a_serial_clock);
    chk(pad_oe[0][3], periph_out.spi_a_serial_clock_oe);
    chk(pad_out[0][1], gpio_out[0][1]);
    chk(periph_in.periodic_timer0_clock_in, pin_in[0][0]);
    chk(periph_in.spi_a_data_in, pin_in[0][2]);
    chk(gpio_in[0][1], pin_in[0][1]);
    sel(8'h00, 8'hcc);
    chk(comparator_in_en[0], 1'b1);
    chk(pad_oe[0][3], 1'b0);
    chk(pad_out[0][1], periph_out.comparator0_output);
    chk(pad_oe[0][1], 1'b1);
    sel(8'h04, 8'hc0);
    chk(analog_channel_en[7], 1'b1);
    chk(periph_in.external_interrupt0, 1'b0);
    sel(8'h0c, 8'hc0);
    chk(analog_channel_en[18], 1'b1);
    chk(gpio_in[1][7], 1'b0);
    chk(pad_oe[1][7], 1'b0);
    sel(8'h04, 8'h01);
    chk(pad_out[0][4], periph_out.spi_a_chip_select);
    chk(pad_oe[0][4], periph_out.spi_a_chip_select_oe);
    chk(periph_in.spi_a_chip_select, pin_in[0][4]);
    sel(8'h08, 8'haa);
    chk(pad_out[1][0], periph_out.serial_data_out_sda);
    chk(pad_oe[1][1], periph_out.serial_data_in_scl_oe);
    chk(periph_in.serial_clock, pin_in[1][2]);
    chk(periph_in.serial_chip_select, pin_in[1][3]);
    sel(8'h14, 8'h0a);
    chk(pad_out[2][4], periph_out.uart_transmit);
    chk(pad_oe[2][4], 1'b1);
    chk(periph_in.uart_receive, pin_in[2][5]);
    $display("test pins done");
    end_sim();
  end
endmodule : tb
